/* File: viu_pkg.sv */
// Package of constants and types for the vectored interrupt unit
package viu_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned VIU_CHANNELS  = 22;
  localparam int unsigned VIU_SLOTS     = 16;
  localparam int unsigned VIU_CHAN_W    = 5;
  localparam int unsigned VIU_SLOT_W    = 4;
  localparam int unsigned VIU_ADDR_W    = 32;

  // ----------------------------------------------------------------
  // Channel numbers
  // ----------------------------------------------------------------
  localparam int unsigned VIU_CH_WATCHDOG  = 0;
  localparam int unsigned VIU_CH_SOFTWARE  = 1;
  localparam int unsigned VIU_CH_DBG_RX    = 2;
  localparam int unsigned VIU_CH_DBG_TX    = 3;
  localparam int unsigned VIU_CH_TIMER0    = 4;
  localparam int unsigned VIU_CH_TIMER1    = 5;
  localparam int unsigned VIU_CH_SERIAL0   = 6;
  localparam int unsigned VIU_CH_SERIAL1   = 7;
  localparam int unsigned VIU_CH_PWM       = 8;
  localparam int unsigned VIU_CH_TWOWIRE0  = 9;
  localparam int unsigned VIU_CH_SYNC_SER  = 10;
  localparam int unsigned VIU_CH_BUF_SER   = 11;
  localparam int unsigned VIU_CH_PLL       = 12;
  localparam int unsigned VIU_CH_RTC       = 13;
  localparam int unsigned VIU_CH_EXT0      = 14;
  localparam int unsigned VIU_CH_ADC0      = 18;
  localparam int unsigned VIU_CH_TWOWIRE1  = 19;
  localparam int unsigned VIU_CH_BROWNOUT  = 20;
  localparam int unsigned VIU_CH_ADC1      = 21;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [VIU_CHANNELS-1:0] VIU_RST_MASK  = 22'h000000;
  localparam logic [VIU_ADDR_W-1:0]   VIU_RST_ADDR  = 32'h00000000;
  localparam logic [VIU_CHAN_W-1:0]   VIU_RST_CHAN  = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   enable;
    logic [VIU_CHAN_W-1:0]  channel;
    logic [VIU_ADDR_W-1:0]  address;
  } viu_slot_t;

  // Software write port for the channel settings and default address; slots are written through viu_slot_wr_t
  typedef struct packed {
    logic                    write;
    logic [VIU_CHANNELS-1:0] chanEnable;
    logic [VIU_CHANNELS-1:0] fastSelect;
    logic [VIU_CHANNELS-1:0] softRequest;
    logic [VIU_ADDR_W-1:0]   defaultAddr;
  } viu_cfg_t;

  typedef struct packed {
    logic                   write;
    logic [VIU_SLOT_W-1:0]  slot;
    viu_slot_t              data;
  } viu_slot_wr_t;

  typedef struct packed {
    logic [VIU_CHANNELS-1:0] rawStatus;
    logic [VIU_CHANNELS-1:0] fastStatus;
    logic [VIU_CHANNELS-1:0] normalStatus;
    logic [VIU_ADDR_W-1:0]   vectorAddr;
    logic                    vectorHit;
    logic [VIU_SLOT_W-1:0]   vectorSlot;
  } viu_status_t;

endpackage

/* File: vectored_interrupt_unit.sv */
// Vectored interrupt unit: classifies, prioritises and reports requests
`timescale 1ns/1ps

// Summary of operation
// R1 - Each line is fast, vectored or non-vectored, per run-time software settings.
// R2 - Fast requests outrank every vectored and non-vectored request.
// R3 - All active fast-class lines are ORed into one fast output.
// R4 - A status word shows which fast-class sources are requesting now.
// R5 - Sixteen vectored slots; software may point any slot at any line.
// R6 - Slot 0 has the highest vectored priority, slot 15 the lowest.
// R7 - Vectored requests rank above non-vectored ones, which rank lowest.
// R8 - Normal output is asserted while any vectored or non-vectored request is active.
// R9 - Vector address returns the address of the best active vectored slot.
// R10 - With no vectored slot active, vector address returns the default address.
// R11 - A status word shows which normal-class requests are active.
// R12 - Each peripheral drives one request line combining its own flags.
// R13 - Channel 0 watchdog, 1 software only, 2 and 3 debug receive/transmit.
// R14 - Channels 4 and 5 carry the two timers' combined match/capture requests.
// R15 - Channels 6 and 7 carry the two asynchronous serial port requests.
// R16 - Channel 8 carries the pulse-width modulator request.
// R17 - Channels 9, 10, 11: two-wire bus 0, sync serial, buffered serial.
// R18 - Channel 12 carries pll lock, channel 13 the real-time clock.
// R19 - Channels 14 to 17 carry external requests zero to three in order.
// R20 - Channels 18 to 21: converter 0, two-wire bus 1, brown-out, converter 1.
// R21 - Disabled channels affect no output, vector or active status; raw stays visible.
// R22 - All settings are clocked registers cleared by reset to disabled, unassigned.
module vectored_interrupt_unit
  import viu_pkg::*;
#(
  parameter int unsigned SLOTS = VIU_SLOTS
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         watchdogTimeoutFlag,
  input  wire logic         debugChannelReceive,
  input  wire logic         debugChannelTransmit,
  input  wire logic [1:0]   timerRequest,
  input  wire logic [1:0]   serialRequest,
  input  wire logic         pwmRequest,
  input  wire logic [1:0]   twoWireRequest,
  input  wire logic         syncSerialRequest,
  input  wire logic         bufSerialRequest,
  input  wire logic         pllLockFlag,
  input  wire logic         rtcRequest,
  input  wire logic [3:0]   externalRequest,
  input  wire logic [1:0]   adcRequest,
  input  wire logic         brownOutDetector,
  input  viu_cfg_t          cfgWrite,
  input  viu_slot_wr_t      slotWrite,
  output logic              fastRequest,
  output logic              normalRequest,
  output viu_status_t       status
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [VIU_CHANNELS-1:0] sync1;
    logic [VIU_CHANNELS-1:0] sync2;
    logic [VIU_CHANNELS-1:0] chanEnable;
    logic [VIU_CHANNELS-1:0] fastSelect;
    logic [VIU_CHANNELS-1:0] softRequest;
    logic [VIU_ADDR_W-1:0]   defaultAddr;
    viu_slot_t [SLOTS-1:0]   slots;
    logic                    fastOut;
    logic                    normalOut;
    viu_status_t             stat;
  } viu_state_t;

  viu_state_t stateQ;
  viu_state_t stateD;

  // ----------------------------------------------------------------
  // Request line map
  // ----------------------------------------------------------------
  // Peripheral lines come from other clocks or pins, so they are synchronised
  logic [VIU_CHANNELS-1:0] pinLines;

  always_comb begin
    pinLines                   = '0;
    pinLines[VIU_CH_WATCHDOG]  = watchdogTimeoutFlag;               // R13
    pinLines[VIU_CH_SOFTWARE]  = 1'b0;                              // R13
    pinLines[VIU_CH_DBG_RX]    = debugChannelReceive;               // R13
    pinLines[VIU_CH_DBG_TX]    = debugChannelTransmit;              // R13
    pinLines[VIU_CH_TIMER0]    = timerRequest[0];                   // R14
    pinLines[VIU_CH_TIMER1]    = timerRequest[1];                   // R14
    pinLines[VIU_CH_SERIAL0]   = serialRequest[0];                  // R15
    pinLines[VIU_CH_SERIAL1]   = serialRequest[1];                  // R15
    pinLines[VIU_CH_PWM]       = pwmRequest;                        // R16
    pinLines[VIU_CH_TWOWIRE0]  = twoWireRequest[0];                 // R17
    pinLines[VIU_CH_SYNC_SER]  = syncSerialRequest;                 // R17
    pinLines[VIU_CH_BUF_SER]   = bufSerialRequest;                  // R17
    pinLines[VIU_CH_PLL]       = pllLockFlag;                       // R18
    pinLines[VIU_CH_RTC]       = rtcRequest;                        // R18
    pinLines[VIU_CH_EXT0+3:VIU_CH_EXT0] = externalRequest;          // R19
    pinLines[VIU_CH_ADC0]      = adcRequest[0];                     // R20
    pinLines[VIU_CH_TWOWIRE1]  = twoWireRequest[1];                 // R20
    pinLines[VIU_CH_BROWNOUT]  = brownOutDetector;                  // R20
    pinLines[VIU_CH_ADC1]      = adcRequest[1];                     // R20
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [VIU_CHANNELS-1:0] rawLines;
  logic [VIU_CHANNELS-1:0] activeLines;
  logic [VIU_CHANNELS-1:0] fastLines;
  logic [VIU_CHANNELS-1:0] normalLines;
  logic                    hit;
  logic [VIU_SLOT_W-1:0]   hitSlot;
  logic [VIU_ADDR_W-1:0]   hitAddr;

  always_comb begin
    stateD = stateQ;

    stateD.sync1 = pinLines;
    stateD.sync2 = stateQ.sync1;

    // Software settings may change at any time
    if (cfgWrite.write) begin
      stateD.chanEnable  = cfgWrite.chanEnable;                     // R1
      stateD.fastSelect  = cfgWrite.fastSelect;                     // R1
      stateD.softRequest = cfgWrite.softRequest;
      stateD.defaultAddr = cfgWrite.defaultAddr;
    end
    if (slotWrite.write && (int'(slotWrite.slot) < SLOTS)) begin
      stateD.slots[slotWrite.slot] = slotWrite.data;                // R5
    end

    // Software-raised lines ride on top of hardware lines
    rawLines    = stateQ.sync2 | stateQ.softRequest;                // R13
    activeLines = rawLines & stateQ.chanEnable;                     // R21
    fastLines   = activeLines & stateQ.fastSelect;                  // R1
    normalLines = activeLines & ~stateQ.fastSelect;                 // R7

    // Highest slot scanned first so slot 0 overrides everything
    hit     = 1'b0;
    hitSlot = '0;
    hitAddr = stateQ.defaultAddr;                                   // R10
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (stateQ.slots[i].enable &&
          (int'(stateQ.slots[i].channel) < VIU_CHANNELS) &&
          normalLines[stateQ.slots[i].channel]) begin
        hit     = 1'b1;                                             // R6
        hitSlot = VIU_SLOT_W'(i);
        hitAddr = stateQ.slots[i].address;                          // R9
      end
    end

    stateD.fastOut             = |fastLines;                        // R3
    stateD.normalOut           = |normalLines;                      // R8
    stateD.stat.rawStatus      = rawLines;
    stateD.stat.fastStatus     = fastLines;                         // R4
    stateD.stat.normalStatus   = normalLines;                       // R11
    stateD.stat.vectorAddr     = hitAddr;
    stateD.stat.vectorHit      = hit;
    stateD.stat.vectorSlot     = hitSlot;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stateQ             <= '0;
      stateQ.chanEnable  <= VIU_RST_MASK;                           // R22
      stateQ.fastSelect  <= VIU_RST_MASK;
      stateQ.softRequest <= VIU_RST_MASK;
      stateQ.defaultAddr <= VIU_RST_ADDR;
      for (int i = 0; i < SLOTS; i++) begin
        stateQ.slots[i].enable  <= 1'b0;                            // R22
        stateQ.slots[i].channel <= VIU_RST_CHAN;
        stateQ.slots[i].address <= VIU_RST_ADDR;
      end
    end else begin
      stateQ <= stateD;
    end
  end

  // Fast wins by being a separate core input; core masks normal while in fast
  assign fastRequest   = stateQ.fastOut;                            // R2
  assign normalRequest = stateQ.normalOut;
  assign status        = stateQ.stat;

endmodule

/* File: viu_core_model.sv */
// Processor-side model that picks the entry it would take
`timescale 1ns/1ps
module viu_core_model
  import viu_pkg::*;
#(
  parameter logic [VIU_ADDR_W-1:0] FAST_ENTRY = 32'h000000f0
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  fastIn,
  input  wire logic                  normalIn,
  input  wire logic [VIU_ADDR_W-1:0] vectorIn,
  output logic      [VIU_ADDR_W-1:0] serviceAddr
);
  // Fast wins when both lines are up; a normal entry uses the vector read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) serviceAddr <= '0;
    else serviceAddr <= fastIn ? FAST_ENTRY : (normalIn ? vectorIn : '0);
  end
endmodule

/* File: viu_checker_asserts.sv */
// Concurrent checks on the vectored interrupt unit ports
`timescale 1ns/1ps
module viu_checker
  import viu_pkg::*;
#(
  parameter int unsigned SLOTS = VIU_SLOTS
) (
  input wire logic    sys_clk,
  input wire logic    nrst,
  input viu_cfg_t     cfgWrite,
  input logic         fastRequest,
  input logic         normalRequest,
  input viu_status_t  status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Settings written, then left alone one cycle, reach the outputs
  // ----------------------------------------------------------------
  sequence softOnly(bit f);
    (cfgWrite.write && cfgWrite.chanEnable[1] && cfgWrite.softRequest[1]
      && cfgWrite.fastSelect[1] == f) ##1 !cfgWrite.write;
  endsequence
  AST_FAST_MERGE: assert property (fastRequest == (|status.fastStatus))
    else $error("fast output differs from fast status");
  AST_NORM_MERGE: assert property (normalRequest == (|status.normalStatus))
    else $error("normal output differs from normal status");
  AST_CLASS_DISJOINT: assert property ((status.fastStatus & status.normalStatus) == '0)
    else $error("line is both fast and normal");
  AST_ENABLED_RAW: assert property (((status.fastStatus | status.normalStatus) & ~status.rawStatus) == '0)
    else $error("active status without raw request");
  AST_HIT_NORMAL: assert property (status.vectorHit |-> normalRequest)
    else $error("vector hit without normal output");
  AST_RESET_CLEAR: assert property ($rose(nrst) |-> !fastRequest && !normalRequest)
    else $error("output active right after reset");
  AST_SOFT_NORMAL: assert property (softOnly(1'b0) |=> status.normalStatus[1] && !status.fastStatus[1])
    else $error("software request not normal two cycles on");
  AST_SOFT_FAST: assert property (softOnly(1'b1) |=> fastRequest && !status.normalStatus[1])
    else $error("fast software request not fast two cycles on");
  AST_ALL_OFF: assert property ((cfgWrite.write && cfgWrite.chanEnable == '0) ##1 !cfgWrite.write |=> !fastRequest && !normalRequest)
    else $error("output active with all channels disabled");
endmodule
bind vectored_interrupt_unit viu_checker #(.SLOTS(SLOTS)) viu_checker_i (.sys_clk(sys_clk), .nrst(nrst),
  .cfgWrite(cfgWrite), .fastRequest(fastRequest), .normalRequest(normalRequest), .status(status));

/* File: tb_vectored_interrupt_unit.sv */
// Self-checking testbench for the vectored interrupt unit
`timescale 1ns/1ps
module tb_vectored_interrupt_unit import viu_pkg::*;;
  logic                    sys_clk, nrst, fastRequest, normalRequest;
  logic [VIU_CHANNELS-1:0] hw;
  logic [VIU_ADDR_W-1:0]   serviceAddr;
  viu_cfg_t                cfg;
  viu_slot_wr_t            sw;
  viu_status_t             status;
  int                      err_count = 0, compares = 0, cyc = 0;
  // One line per peripheral, placed at its channel; line 1 has no source
  vectored_interrupt_unit vectored_interrupt_unit_i (.sys_clk(sys_clk), .nrst(nrst),
    .watchdogTimeoutFlag(hw[0]), .debugChannelReceive(hw[2]), .debugChannelTransmit(hw[3]),
    .timerRequest(hw[5:4]), .serialRequest(hw[7:6]), .pwmRequest(hw[8]),
    .twoWireRequest({hw[19], hw[9]}), .syncSerialRequest(hw[10]), .bufSerialRequest(hw[11]),
    .pllLockFlag(hw[12]), .rtcRequest(hw[13]), .externalRequest(hw[17:14]),
    .adcRequest({hw[21], hw[18]}), .brownOutDetector(hw[20]), .cfgWrite(cfg), .slotWrite(sw),
    .fastRequest(fastRequest), .normalRequest(normalRequest), .status(status));
  viu_core_model viu_core_model_i (.sys_clk(sys_clk), .nrst(nrst), .fastIn(fastRequest),
    .normalIn(normalRequest), .vectorIn(status.vectorAddr), .serviceAddr(serviceAddr));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      test_done();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Waits past both the settings stage and the line synchronisers
  task automatic set_cfg(input logic [21:0] en, fs, sr, input logic [31:0] da);
    cfg = '{1'b1, en, fs, sr, da};
    wait_n(1);
    cfg.write = 1'b0;
    wait_n(4);
  endtask
  task automatic set_slot(input logic [3:0] s, input logic [4:0] ch, input logic [31:0] a);
    sw = '{1'b1, s, '{1'b1, ch, a}};
    wait_n(1);
    sw.write = 1'b0;
    wait_n(1);
  endtask
  task automatic t_soft();
    set_cfg(22'h000002, 22'h000000, 22'h000002, 32'h00000a00);
    check(normalRequest, 1'b1);
    check(status.normalStatus, 22'h000002);
    check(status.vectorAddr, 32'h00000a00);
    set_cfg(22'h000002, 22'h000002, 22'h000002, 32'h00000a00);
    check({fastRequest, normalRequest}, 2'h2);
    check(status.fastStatus, 22'h000002);
    set_cfg(22'h000000, 22'h000000, 22'h000000, 32'h00000000);
  endtask
  task automatic t_map();
    set_cfg(22'h3fffff, 22'h000000, 22'h000000, 32'h00000b00);
    for (int c = 0; c < 22; c++) begin
      if (c == 1) continue;
      hw = 22'h000001 << c;
      wait_n(4);
      check(status.rawStatus, hw);
      check(status.normalStatus, hw);
    end
    hw = '0;
  endtask
  task automatic t_vector();
    set_slot(4'hf, 5'h04, 32'h00000c15);
    set_slot(4'h0, 5'h0e, 32'h00000c00);
    hw[4] = 1'b1;
    hw[14] = 1'b1;
    wait_n(4);
    check(status.vectorAddr, 32'h00000c00);
    check(status.vectorSlot, 4'h0);
    check(serviceAddr, 32'h00000c00);
    hw[14] = 1'b0;
    wait_n(4);
    check(status.vectorAddr, 32'h00000c15);
    hw[20] = 1'b1;
    set_cfg(22'h3fffff, 22'h000010, 22'h000000, 32'h00000b00);
    check({fastRequest, normalRequest, status.vectorHit}, 3'h6);
    check(status.vectorAddr, 32'h00000b00);
    check(serviceAddr, 32'h000000f0);
    set_cfg(22'h000000, 22'h000000, 22'h000000, 32'h00000b00);
    check(status.rawStatus, 22'h100010);
    check({fastRequest, normalRequest}, 2'h0);
    hw = '0;
  endtask
  initial begin
    nrst = 1'b0;
    hw = '0;
    cfg = '0;
    sw = '0;
    wait_n(2);
    nrst = 1'b1;
    wait_n(1);
    check({fastRequest, normalRequest, status.vectorAddr}, 34'h0);
    t_soft();
    t_map();
    t_vector();
    test_done();
  end
endmodule
